// file: hw/plsc_lane_mux.sv
// Four-lane source multiplexer with same-numbered channel routing
`timescale 1ns/1ps
`default_nettype none
module plsc_lane_mux (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       enable,
   input  wire logic [3:0] sel_onehot,
   input  wire logic [3:0] src_a,
   input  wire logic [3:0] src_b,
   input  wire logic [3:0] src_c,
   input  wire logic [3:0] src_d,
   output logic      [3:0] lanes_out
);
   import plsc_pkg::*;

   logic [3:0] next_lanes_out;

   // -------------------------------------------------------------------------
   // Per-channel selection
   // -------------------------------------------------------------------------
   // Same structure for every lane, so any lane may carry the clock
   // [R10] identical lane slices
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHANNELS; ch = ch + 1) begin : g_lane
         // [R9] same-numbered routing
         // One driver per bit, so the lane slices stay independent
         assign next_lanes_out[ch] = enable & ((sel_onehot[0] & src_a[ch]) |
                                               (sel_onehot[1] & src_b[ch]) |
                                               (sel_onehot[2] & src_c[ch]) |
                                               (sel_onehot[3] & src_d[ch]));

         // [R9] lane follows its own channel
         AST_LANE_ROUTE: assert property (@(posedge aclk) disable iff (!aresetn)
            enable && sel_onehot[2] |=> lanes_out[ch] == $past(src_c[ch])) // [R9]
            else $error("lane not routed from same-numbered source channel");
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lanes_out <= 4'h0;
      end else begin
         lanes_out <= next_lanes_out;
      end
   end

endmodule // plsc_lane_mux
`default_nettype wire

// file: hw/plsc_pkg.sv
// Shared constants, types and decode functions for the parallel pin link switch configuration block
// ----------------------------------------------------------------------------
// Operation
// [R1] Source code 00..11 picks auxiliary group A..D
// [R2] Input terminations always on, pins cannot disable
// [R3] Pulse-on-source termination switching always off
// [R4] One equalization pin sets every input channel
// [R5] Equalization pin 0 gives 6 dB, 1 gives 12 dB
// [R6] Pre-emphasis codes give 0, 2, 4, 6 dB
// [R7] Output termination pin 0 off, 1 on
// [R8] Output current pin 0 10 mA, 1 20 mA
// [R9] Output channel n takes only input channel n
// [R10] All four lanes handled by identical logic
// [R11] Enable pin 0 standby channels off, 1 on; the code also keeps channels off at pin 1 while the control standby bit is set
// [R12] Same source code picks high-speed group A..D
// [R13] Auxiliary switch always enabled, quad grouping fixed
// [R14] Settings follow pin levels, no strobe needed
// ----------------------------------------------------------------------------
package plsc_pkg;

   // -------------------------------------------------------------------------
   // Bus and register map
   // -------------------------------------------------------------------------
   localparam int          ADDR_W            = 8;
   localparam logic [7:0]  CONTROL_OFFSET    = 8'h00;
   localparam logic [7:0]  STATUS_OFFSET     = 8'h04;
   localparam logic [31:0] CONTROL_RESET     = 32'h0000_0000;
   localparam int          CTRL_STANDBY_BIT  = 0;
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   // Status field positions
   localparam int          ST_HS_ON_BIT      = 0;
   localparam int          ST_SOURCE_LSB     = 1;
   localparam int          ST_EQ_BIT         = 3;
   localparam int          ST_PE_LSB         = 4;
   localparam int          ST_OTERM_BIT      = 6;
   localparam int          ST_CURRENT_BIT    = 7;
   localparam int          ST_ITERM_BIT      = 8;
   localparam int          ST_PULSE_BIT      = 9;
   localparam int          ST_AUX_EN_BIT     = 10;
   localparam int          ST_AUX_QUAD_BIT   = 11;

   // -------------------------------------------------------------------------
   // Switch geometry and analog settings
   // -------------------------------------------------------------------------
   localparam int          NUM_SOURCES       = 4;
   localparam int          NUM_CHANNELS      = 4;
   localparam int          NUM_INPUTS        = 16;
   localparam logic [3:0]  EQ_LOW_DB         = 4'h6;
   localparam logic [3:0]  EQ_HIGH_DB        = 4'hc;
   localparam logic [4:0]  CURRENT_LOW_MA    = 5'h0a;
   localparam logic [4:0]  CURRENT_HIGH_MA   = 5'h14;
   localparam logic        INPUT_TERM_FIXED  = 1'h1;
   localparam logic        PULSE_SW_FIXED    = 1'h0;
   localparam logic        AUX_ENABLE_FIXED  = 1'h1;
   localparam logic        AUX_QUAD_FIXED    = 1'h1;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP    = 2'b10
   } plsc_wr_state_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } plsc_rd_state_t;

   // Code 00..11 to one-hot source A..D
   function automatic logic [3:0] decode_source(input logic [1:0] code);
      logic [3:0] onehot;
      onehot       = 4'h0;
      onehot[code] = 1'b1;
      return onehot;
   endfunction

   // Pre-emphasis in dB: 0, 2, 4, 6
   function automatic logic [2:0] preemph_to_db(input logic [1:0] code);
      return {code, 1'b0};
   endfunction

endpackage

// file: hw/plsc_top.sv
// Parallel pin decode, register slave and lane switch for the four-to-one link switch
`timescale 1ns/1ps
`default_nettype none
module plsc_top (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // AXI4-Lite slave
   input  wire logic [plsc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                  s_axi_awprot,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [plsc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                  s_axi_arprot,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // Parallel control pins
   input  wire logic [1:0]                  source_select_pins,
   input  wire logic                        high_speed_enable_pin,
   input  wire logic                        equalization_level_pin,
   input  wire logic [1:0]                  preemphasis_level_pins,
   input  wire logic                        output_termination_pin,
   input  wire logic                        output_current_pin,
   // Digital lane images of the four sources
   input  wire logic [3:0]                  hs_lanes_a,
   input  wire logic [3:0]                  hs_lanes_b,
   input  wire logic [3:0]                  hs_lanes_c,
   input  wire logic [3:0]                  hs_lanes_d,
   output logic [3:0]                       hs_lanes_out,
   // Decoded switch settings
   output logic                             hs_channels_on,
   output logic [3:0]                       hs_source_onehot,
   output logic [3:0]                       aux_source_onehot,
   output logic                             aux_switch_enable,
   output logic                             aux_quad_mode,
   output logic [15:0]                      input_termination_on,
   output logic [15:0]                      pulse_switch_enable,
   output logic [15:0]                      eq_level_high,
   output logic [3:0]                       eq_db,
   output logic [1:0]                       preemph_level,
   output logic [2:0]                       preemph_db,
   output logic                             output_termination_on,
   output logic                             tx_current_level,
   output logic [4:0]                       tx_current_ma
);
   import plsc_pkg::*;

   // -------------------------------------------------------------------------
   // Register bus state
   // -------------------------------------------------------------------------
   plsc_wr_state_t    wr_state;
   plsc_wr_state_t    next_wr_state;
   plsc_rd_state_t    rd_state;
   plsc_rd_state_t    next_rd_state;
   logic              aw_held;
   logic              next_aw_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [ADDR_W-1:0] next_aw_addr;
   logic              w_held;
   logic              next_w_held;
   logic [31:0]       w_data;
   logic [31:0]       next_w_data;
   logic [3:0]        w_strb;
   logic [3:0]        next_w_strb;
   logic [1:0]        next_bresp;
   logic [31:0]       next_rdata;
   logic [1:0]        next_rresp;
   logic [31:0]       control;
   logic [31:0]       next_control;
   logic              aw_take;
   logic              w_take;
   logic              wr_fire;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0]       wr_data;
   logic [3:0]        wr_strb;
   logic [31:0]       status_word;

   // -------------------------------------------------------------------------
   // Setting state
   // -------------------------------------------------------------------------
   logic [1:0]        source_code;
   logic [1:0]        next_source_code;
   logic              next_hs_on;
   logic              next_eq_high;
   logic [1:0]        next_pe;
   logic              next_oterm;
   logic              next_current;

   // Word-aligned register hit, used by both read and write paths
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] offset);
      return addr[ADDR_W-1:2] == offset[ADDR_W-1:2];
   endfunction

   // -------------------------------------------------------------------------
   // Write channel
   // -------------------------------------------------------------------------
   // Address and data may arrive in either order; each is parked until both are in
   assign s_axi_awready = (wr_state == WR_COLLECT) && !aw_held;
   assign s_axi_wready  = (wr_state == WR_COLLECT) && !w_held;
   assign s_axi_bvalid  = (wr_state == WR_RESP);
   assign aw_take       = s_axi_awvalid && s_axi_awready;
   assign w_take        = s_axi_wvalid && s_axi_wready;
   assign wr_addr       = aw_held ? aw_addr : s_axi_awaddr;
   assign wr_data       = w_held ? w_data : s_axi_wdata;
   assign wr_strb       = w_held ? w_strb : s_axi_wstrb;
   assign wr_fire       = (wr_state == WR_COLLECT) && (aw_held || aw_take) && (w_held || w_take);

   always_comb begin
      next_wr_state = wr_state;
      next_aw_held  = aw_held;
      next_aw_addr  = aw_addr;
      next_w_held   = w_held;
      next_w_data   = w_data;
      next_w_strb   = w_strb;
      next_bresp    = s_axi_bresp;
      next_control  = control;
      case (wr_state)
         WR_COLLECT: begin
            if (aw_take) begin
               next_aw_held = 1'b1;
               next_aw_addr = s_axi_awaddr;
            end
            if (w_take) begin
               next_w_held = 1'b1;
               next_w_data = s_axi_wdata;
               next_w_strb = s_axi_wstrb;
            end
            if (wr_fire) begin
               next_aw_held  = 1'b0;
               next_w_held   = 1'b0;
               next_wr_state = WR_RESP;
               next_bresp    = RESP_OKAY;
               if (reg_hit(wr_addr, CONTROL_OFFSET)) begin
                  // Only the standby bit is implemented; other bits stay zero
                  if (wr_strb[0]) begin
                     next_control[CTRL_STANDBY_BIT] = wr_data[CTRL_STANDBY_BIT];
                  end
               end else if (!reg_hit(wr_addr, STATUS_OFFSET)) begin
                  next_bresp = RESP_SLVERR;
               end
            end
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               next_wr_state = WR_COLLECT;
            end
         end
         default: begin
            next_wr_state = WR_COLLECT;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state    <= WR_COLLECT;
         aw_held     <= 1'b0;
         aw_addr     <= '0;
         w_held      <= 1'b0;
         w_data      <= 32'h0000_0000;
         w_strb      <= 4'h0;
         s_axi_bresp <= RESP_OKAY;
         control     <= CONTROL_RESET;
      end else begin
         wr_state    <= next_wr_state;
         aw_held     <= next_aw_held;
         aw_addr     <= next_aw_addr;
         w_held      <= next_w_held;
         w_data      <= next_w_data;
         w_strb      <= next_w_strb;
         s_axi_bresp <= next_bresp;
         control     <= next_control;
      end
   end

   // -------------------------------------------------------------------------
   // Read channel
   // -------------------------------------------------------------------------
   assign s_axi_arready = (rd_state == RD_IDLE);
   assign s_axi_rvalid  = (rd_state == RD_DATA);

   always_comb begin
      status_word                   = 32'h0000_0000;
      status_word[ST_HS_ON_BIT]     = hs_channels_on;
      status_word[ST_SOURCE_LSB+:2] = source_code;
      status_word[ST_EQ_BIT]        = eq_level_high[0];
      status_word[ST_PE_LSB+:2]     = preemph_level;
      status_word[ST_OTERM_BIT]     = output_termination_on;
      status_word[ST_CURRENT_BIT]   = tx_current_level;
      status_word[ST_ITERM_BIT]     = input_termination_on[0];
      status_word[ST_PULSE_BIT]     = pulse_switch_enable[0];
      status_word[ST_AUX_EN_BIT]    = aux_switch_enable;
      status_word[ST_AUX_QUAD_BIT]  = aux_quad_mode;
   end

   always_comb begin
      next_rd_state = rd_state;
      next_rdata    = s_axi_rdata;
      next_rresp    = s_axi_rresp;
      case (rd_state)
         RD_IDLE: begin
            if (s_axi_arvalid) begin
               next_rd_state = RD_DATA;
               next_rresp    = RESP_OKAY;
               if (reg_hit(s_axi_araddr, CONTROL_OFFSET)) begin
                  next_rdata = control;
               end else if (reg_hit(s_axi_araddr, STATUS_OFFSET)) begin
                  next_rdata = status_word;
               end else begin
                  next_rdata = 32'h0000_0000;
                  next_rresp = RESP_SLVERR;
               end
            end
         end
         RD_DATA: begin
            if (s_axi_rready) begin
               next_rd_state = RD_IDLE;
            end
         end
         default: begin
            next_rd_state = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state    <= RD_IDLE;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         rd_state    <= next_rd_state;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   // -------------------------------------------------------------------------
   // Pin decode
   // -------------------------------------------------------------------------
   // Pins are levels, resampled every cycle; latency is one clock, no strobe
   // [R14] level-sampled pins
   always_comb begin
      next_source_code = source_select_pins;
      // [R11] enable pin standby
      next_hs_on       = high_speed_enable_pin && !control[CTRL_STANDBY_BIT];
      next_eq_high     = equalization_level_pin;
      next_pe          = preemphasis_level_pins;
      next_oterm       = output_termination_pin;
      next_current     = output_current_pin;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         source_code           <= 2'h0;
         hs_channels_on        <= 1'b0;
         hs_source_onehot      <= 4'h1;
         aux_source_onehot     <= 4'h1;
         eq_level_high         <= 16'h0000;
         eq_db                 <= EQ_LOW_DB;
         preemph_level         <= 2'h0;
         preemph_db            <= 3'h0;
         output_termination_on <= 1'b0;
         tx_current_level      <= 1'b0;
         tx_current_ma         <= CURRENT_LOW_MA;
      end else begin
         source_code           <= next_source_code;
         hs_channels_on        <= next_hs_on;
         // [R12] high-speed source select
         hs_source_onehot      <= decode_source(next_source_code);
         // [R1] auxiliary source select
         aux_source_onehot     <= decode_source(next_source_code);
         // [R4] one level for all inputs
         eq_level_high         <= {NUM_INPUTS{next_eq_high}};
         // [R5] equalization level
         eq_db                 <= next_eq_high ? EQ_HIGH_DB : EQ_LOW_DB;
         // [R6] pre-emphasis level
         preemph_level         <= next_pe;
         preemph_db            <= preemph_to_db(next_pe);
         // [R7] output back-termination
         output_termination_on <= next_oterm;
         // [R8] drive current
         tx_current_level      <= next_current;
         tx_current_ma         <= next_current ? CURRENT_HIGH_MA : CURRENT_LOW_MA;
      end
   end

   // -------------------------------------------------------------------------
   // Fixed settings
   // -------------------------------------------------------------------------
   // No pin or register reaches these in parallel operation
   // [R2] terminations forced on
   assign input_termination_on = {NUM_INPUTS{INPUT_TERM_FIXED}};
   // [R3] pulse switching forced off
   assign pulse_switch_enable  = {NUM_INPUTS{PULSE_SW_FIXED}};
   // [R13] auxiliary switch fixed
   assign aux_switch_enable    = AUX_ENABLE_FIXED;
   assign aux_quad_mode        = AUX_QUAD_FIXED;

   // -------------------------------------------------------------------------
   // Lane switch
   // -------------------------------------------------------------------------
   plsc_lane_mux u_lane_mux (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .enable     (hs_channels_on),
      .sel_onehot (hs_source_onehot),
      .src_a      (hs_lanes_a),
      .src_b      (hs_lanes_b),
      .src_c      (hs_lanes_c),
      .src_d      (hs_lanes_d),
      .lanes_out  (hs_lanes_out)
   );

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   // [R1] aux select tracks code
   AST_AUX_SOURCE: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> aux_source_onehot == decode_source($past(source_select_pins))) // [R1]
      else $error("auxiliary source does not follow select code");

   // [R2] terminations on
   AST_INPUT_TERM: assert property (@(posedge aclk) disable iff (!aresetn)
      input_termination_on == 16'hffff) // [R2]
      else $error("input termination not held on");

   // [R3] pulse switching off
   AST_PULSE_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      pulse_switch_enable == 16'h0000) // [R3]
      else $error("pulse-on-source switching not held off");

   // [R4] global equalization
   AST_EQ_GLOBAL: assert property (@(posedge aclk) disable iff (!aresetn)
      (&eq_level_high) || !(|eq_level_high)) // [R4]
      else $error("equalization differs between input channels");

   // [R5] equalization figure
   AST_EQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(equalization_level_pin) |=> eq_db == 4'hc ##1 (eq_db == 4'hc) || $past(!equalization_level_pin)) // [R5]
      else $error("equalization level not 12 dB after pin high");

   // [R6] pre-emphasis figure
   AST_PREEMPH: assert property (@(posedge aclk) disable iff (!aresetn)
      preemphasis_level_pins == 2'h3 |=> preemph_db == 3'h6 && preemph_level == 2'h3) // [R6]
      else $error("pre-emphasis not 6 dB for code 11");

   // [R7] termination follows pin
   AST_OUT_TERM: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(output_termination_pin) |=> output_termination_on == $past(output_termination_pin)) // [R7]
      else $error("output termination did not follow its pin");

   // [R8] drive current ties level
   AST_CURRENT: assert property (@(posedge aclk) disable iff (!aresetn)
      tx_current_ma == (tx_current_level ? 5'h14 : 5'h0a)) // [R8]
      else $error("output current does not match level");

   // [R11] standby blanks lanes
   AST_STANDBY: assert property (@(posedge aclk) disable iff (!aresetn)
      !high_speed_enable_pin ##1 !high_speed_enable_pin |=> !hs_channels_on && hs_lanes_out == 4'h0) // [R11]
      else $error("lanes active while enable pin low");

   // [R12] both switches share the code
   AST_HS_SOURCE: assert property (@(posedge aclk) disable iff (!aresetn)
      hs_source_onehot == aux_source_onehot && $onehot(hs_source_onehot)) // [R12]
      else $error("high-speed source differs from auxiliary source");

   // [R13] aux switch fixed
   AST_AUX_FIXED: assert property (@(posedge aclk) disable iff (!aresetn)
      aux_switch_enable && aux_quad_mode) // [R13]
      else $error("auxiliary switch not enabled in quad grouping");

   // [R14] change lands in one cycle
   AST_PIN_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(source_select_pins) |=> source_code == $past(source_select_pins)) // [R14]
      else $error("source code did not follow pin change");

   AST_BRESP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before acceptance");

endmodule // plsc_top
`default_nettype wire

// file: verif/plsc_strap_model.sv
// Board strap model driving the parallel control pins
`timescale 1ns/1ps
`default_nettype none
module plsc_strap_model (
   input  wire logic [7:0] cfg,
   output logic      [1:0] src,
   output logic            en,
   output logic            eq,
   output logic      [1:0] pe,
   output logic            ot,
   output logic            cu
);
   // Straps are static levels, so they follow the setting with no clock
   assign {cu, ot, pe, eq, en, src} = cfg;
endmodule // plsc_strap_model
`default_nettype wire

// file: verif/tb.sv
// Pin sweep and register bus tests for the link switch configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import plsc_pkg::*;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [7:0] awa = 0, ara = 0, cfg = 0;
   logic [31:0] wd = 0, d;
   logic [3:0] ws = 0, la = 0, lb = 0, lc = 0, ld = 0;
   logic [1:0] r;
   wire logic awr, wrd, bv, arr, rv, hon, aen, aq, oto, tcl, en, eq, ot, cu;
   wire logic [1:0] br, rr, src, pe, pel;
   wire logic [2:0] ped;
   wire logic [3:0] lo, hso, axo, edb;
   wire logic [4:0] tma;
   wire logic [15:0] it, ps, eqh;
   wire logic [31:0] rdd;
   int n_fail = 0, cmp_count = 0, cyc = 0;
   wire logic [78:0] got = {hon, hso, axo, aen, aq, it, ps, eqh, edb, pel, ped, oto, tcl, tma, lo};
   always #2 aclk = ~aclk;
   plsc_strap_model pm (.cfg(cfg), .src(src), .en(en), .eq(eq), .pe(pe), .ot(ot), .cu(cu));
   plsc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .source_select_pins(src), .high_speed_enable_pin(en), .equalization_level_pin(eq),
      .preemphasis_level_pins(pe), .output_termination_pin(ot), .output_current_pin(cu), .hs_lanes_a(la),
      .hs_lanes_b(lb), .hs_lanes_c(lc), .hs_lanes_d(ld), .hs_lanes_out(lo), .hs_channels_on(hon),
      .hs_source_onehot(hso), .aux_source_onehot(axo), .aux_switch_enable(aen), .aux_quad_mode(aq),
      .input_termination_on(it), .pulse_switch_enable(ps), .eq_level_high(eqh), .eq_db(edb),
      .preemph_level(pel), .preemph_db(ped), .output_termination_on(oto), .tx_current_level(tcl),
      .tx_current_ma(tma));
   function automatic logic [78:0] ex(input logic [7:0] c, input logic sb);
      logic h;
      h = c[2] & ~sb;
      return {h, 4'h1 << c[1:0], 4'h1 << c[1:0], 2'b11, 16'hffff, 16'h0000, {16{c[3]}}, c[3] ? 4'hc : 4'h6,
              c[5:4], c[5:4], 1'b0, c[6], c[7], c[7] ? 5'h14 : 5'h0a, h ? 4'({ld, lc, lb, la} >> (4 * c[1:0])) : 4'h0};
   endfunction
   task chk(input logic [78:0] g, input logic [78:0] x);
      cmp_count++;
      if (g !== x) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
      @(posedge aclk);
      awa <= a; wd <= v; ws <= s; awv <= 1; wv <= 1; bry <= 1;
      // Hold each channel until its own ready; the response is not assumed to take any fixed time
      do begin
         @(posedge aclk);
         if (awv && awr) awv <= 0;
         if (wv && wrd) wv <= 0;
      end while (!bv);
      r = br;
      bry <= 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge aclk);
      ara <= a; arv <= 1; rry <= 1;
      do begin
         @(posedge aclk);
         if (arv && arr) arv <= 0;
      end while (!rv);
      r = rr;
      d = rdd;
      rry <= 0;
   endtask
   task results;
      $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Cut a hang short; the whole run needs about 800 cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         results;
      end
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      for (int i = 0; i < 256; i++) begin
         cfg <= i[7:0]; la <= i[7:4]; lb <= i[3:0]; lc <= ~i[7:4]; ld <= ~i[3:0];
         repeat (3) @(posedge aclk);
         chk(got, ex(i[7:0], 1'b0));
      end
      $display("test pin sweep done");
      cfg <= 8'h96;
      wr(CONTROL_OFFSET, 32'h0000_0001, 4'h1);
      repeat (3) @(posedge aclk);
      chk({r, got}, {RESP_OKAY, ex(8'h96, 1'b1)});
      rd(STATUS_OFFSET);
      chk({r, d}, {RESP_OKAY, 32'h0000_0d94});
      wr(CONTROL_OFFSET, 32'h0000_0000, 4'h0);
      rd(CONTROL_OFFSET);
      chk({r, d}, {RESP_OKAY, 32'h0000_0001});
      wr(STATUS_OFFSET, 32'hffff_ffff, 4'hf);
      chk(r, RESP_OKAY);
      wr(8'h08, 32'h0000_0001, 4'hf);
      chk(r, RESP_SLVERR);
      rd(8'h08);
      chk({r, d}, {RESP_SLVERR, 32'h0000_0000});
      wr(CONTROL_OFFSET, 32'h0000_0000, 4'hf);
      rd(STATUS_OFFSET);
      chk({r, d, got}, {RESP_OKAY, 32'h0000_0d95, ex(8'h96, 1'b0)});
      $display("test register bus done");
      results;
   end
endmodule // tb
`default_nettype wire
